// *** hw/ccs_core.sv ***
// Summary of operation
// - Work register also at data address FFh
// - Pointers at 80h, 81h drive indirect addresses
// - Twelve-bit program counter, 4096 bytes
// - Increment counter on sequential fetch
// - Branch adds signed offset to counter
// - Jump, call, vector, return load counter
// - Three carry/zero pairs, one per context
// - Switch pair on entry, restore on exit
// - Pairs keep values across context switches
// - Only active context pair is touched
// - Carry from arithmetic, logic, bit test, rotate
// - Zero flag follows result equals zero on arithmetic and logic only
// - Reset starts in nonmaskable context
// - Six-level twelve-bit return stack
// - Call shifts levels up, pushes counter
// - Return pops first level, shifts down
// - Deep nesting saturates, oldest lost
// - Return on empty stack falls through
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defines.svh"
module ccs_core
  import ccs_pkg::*;
(
  input wire logic CLK, // Core clock
  input wire logic RSTN, // Async reset, active low
  input wire logic [2:0] PC_OP, // Counter operation code
  input wire logic [`CCS_PC_W-1:0] PC_TARGET, // Jump, call or vector address
  input wire logic [7:0] BRANCH_OFFSET, // Signed relative offset
  input wire logic ENTER_IRQ, // Entry into maskable service
  input wire logic ENTER_NMI, // Entry into nonmaskable service
  input wire logic [7:0] DATA_ADDR, // Data-space address
  input wire logic DATA_WE, // Data-space write strobe
  input wire logic [7:0] DATA_WDATA, // Data-space write data
  input wire logic WORK_WE, // Direct work register write
  input wire logic [7:0] WORK_WDATA, // Work register write data
  input wire logic FLAG_WE, // Update flags of active context
  input wire logic [1:0] FLAG_SRC, // 0 arith, 1 logic, 2 bit test, 3 rotate
  input wire logic [7:0] RESULT, // Operation result
  input wire logic CARRY_IN, // Arithmetic carry/borrow or tested bit
  output logic [`CCS_PC_W-1:0] PROGRAM_COUNTER, // Program counter
  output logic [7:0] DATA_RDATA, // Data-space read data
  output logic DATA_HIT, // Address maps to this block
  output logic [7:0] WORK, // Work register
  output logic [7:0] PTR1, // First pointer
  output logic [7:0] PTR2, // Second pointer
  output logic CARRY, // Carry of active context
  output logic ZERO, // Zero of active context
  output logic [1:0] CONTEXT, // Active context
  output logic [`CCS_LVL_W-1:0] STACK_LEVEL // Levels in use
);
  logic [7:0] sd1;
  logic [7:0] sd2;
  logic carry_f [`CCS_N_CTX];
  logic zero_f [`CCS_N_CTX];
  ccs_ctx_e ctx;
  ccs_ctx_e next_ctx;
  ccs_ctx_e prev_ctx [`CCS_DEPTH];
  ccs_pcop_e op;
  logic push;
  logic pop;
  logic [`CCS_PC_W-1:0] stk_top;
  logic stk_empty;
  logic [`CCS_LVL_W-1:0] stk_level;
  logic [`CCS_PC_W-1:0] next_pc;
  logic [7:0] next_rdata;
  logic next_hit;
  logic [1:0] idx;
  logic entry;
  logic irq_exit;
  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == `CCS_ADDR_PTR1) || (a == `CCS_ADDR_PTR2) ||
             (a == `CCS_ADDR_SD1) || (a == `CCS_ADDR_SD2) || (a == `CCS_ADDR_WORK);
  endfunction
  // Data-space write strobe decode, shared by every mapped register
  function automatic logic wr_at(input logic we, input logic [7:0] a, input logic [7:0] loc);
    wr_at = we && (a == loc);
  endfunction
  assign op = ccs_pcop_e'(PC_OP);
  always_comb begin
    push = 1'b0;
    pop = 1'b0;
    entry = 1'b0;
    irq_exit = 1'b0;
    case (op)
      CCS_PC_CALL: begin
        push = 1'b1;
      end
      CCS_PC_INTR: begin
        push = 1'b1;
        entry = 1'b1;
      end
      CCS_PC_RET: begin
        pop = 1'b1;
      end
      CCS_PC_INTERRUPT_EXIT_INSTR: begin
        pop = 1'b1;
        irq_exit = 1'b1;
      end
      default: begin
      end
    endcase
  end
  assign idx = ctx;
  ccs_return_stack u_stack (
    .clk(CLK),
    .rst_n(RSTN),
    .push(push),
    .pop(pop),
    .push_data(PROGRAM_COUNTER),
    .top(stk_top),
    .empty(stk_empty),
    .level(stk_level)
  );
  always_comb begin
    next_pc = PROGRAM_COUNTER;
    case (op)
      CCS_PC_HOLD: begin
        next_pc = PROGRAM_COUNTER;
      end
      CCS_PC_INC: begin
        next_pc = PROGRAM_COUNTER + `CCS_PC_ONE;
      end
      CCS_PC_JUMP, CCS_PC_CALL, CCS_PC_INTR: begin
        next_pc = PC_TARGET;
      end
      CCS_PC_BRANCH: begin
        next_pc = PROGRAM_COUNTER + {{(`CCS_PC_W-8){BRANCH_OFFSET[7]}}, BRANCH_OFFSET};
      end
      CCS_PC_RET, CCS_PC_INTERRUPT_EXIT_INSTR: begin
        next_pc = stk_empty ? PROGRAM_COUNTER + `CCS_PC_ONE : stk_top;
      end
      default: begin
        next_pc = PROGRAM_COUNTER;
      end
    endcase
  end
  // Twelve-bit counter, starts at reset vector
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PROGRAM_COUNTER <= `CCS_RESET_VECTOR;
    end else begin
      PROGRAM_COUNTER <= next_pc;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WORK <= `CCS_REG_RESET;
    end else if (wr_at(DATA_WE, DATA_ADDR, `CCS_ADDR_WORK)) begin
      WORK <= DATA_WDATA;
    end else if (WORK_WE) begin
      WORK <= WORK_WDATA;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PTR1 <= `CCS_REG_RESET;
    end else if (wr_at(DATA_WE, DATA_ADDR, `CCS_ADDR_PTR1)) begin
      PTR1 <= DATA_WDATA;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PTR2 <= `CCS_REG_RESET;
    end else if (wr_at(DATA_WE, DATA_ADDR, `CCS_ADDR_PTR2)) begin
      PTR2 <= DATA_WDATA;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sd1 <= `CCS_REG_RESET;
    end else if (wr_at(DATA_WE, DATA_ADDR, `CCS_ADDR_SD1)) begin
      sd1 <= DATA_WDATA;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sd2 <= `CCS_REG_RESET;
    end else if (wr_at(DATA_WE, DATA_ADDR, `CCS_ADDR_SD2)) begin
      sd2 <= DATA_WDATA;
    end
  end
  // Read data registered; shows the value before any write in the same cycle
  always_comb begin
    next_hit = is_reg(DATA_ADDR);
    case (DATA_ADDR)
      `CCS_ADDR_PTR1: next_rdata = PTR1;
      `CCS_ADDR_PTR2: next_rdata = PTR2;
      `CCS_ADDR_SD1: next_rdata = sd1;
      `CCS_ADDR_SD2: next_rdata = sd2;
      `CCS_ADDR_WORK: next_rdata = WORK;
      default: next_rdata = `CCS_ZERO_BYTE;
    endcase
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_RDATA <= `CCS_REG_RESET;
      DATA_HIT <= 1'b0;
    end else begin
      DATA_RDATA <= next_rdata;
      DATA_HIT <= next_hit;
    end
  end
  always_comb begin
    next_ctx = ctx;
    if (entry && ENTER_NMI) begin
      next_ctx = CCS_CTX_NMI;
    end else if (entry && ENTER_IRQ) begin
      next_ctx = CCS_CTX_IRQ;
    end else if (irq_exit) begin
      next_ctx = prev_ctx[0];
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctx <= CCS_CTX_NMI;
    end else begin
      ctx <= next_ctx;
    end
  end
  // History moves on entry and exit only
  // Calls and plain returns inside service must not disturb it
  genvar g;
  generate
    for (g = 0; g < `CCS_DEPTH; g++) begin : g_prev
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          prev_ctx[g] <= CCS_CTX_NORMAL;
        end else if (entry) begin
          if (g == 0) begin
            prev_ctx[g] <= ctx;
          end else begin
            prev_ctx[g] <= prev_ctx[g-1];
          end
        end else if (irq_exit) begin
          if (g == `CCS_DEPTH-1) begin
            prev_ctx[g] <= CCS_CTX_NORMAL;
          end else begin
            prev_ctx[g] <= prev_ctx[g+1];
          end
        end
      end
    end
  endgenerate
  generate
    for (g = 0; g < `CCS_N_CTX; g++) begin : g_flag
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          carry_f[g] <= `CCS_FLAG_RESET;
          zero_f[g] <= `CCS_FLAG_RESET;
        end else if (FLAG_WE && idx == 2'(g)) begin
          case (FLAG_SRC)
            `CCS_SRC_ARITH, `CCS_SRC_LOGIC: begin
              carry_f[g] <= CARRY_IN;
              zero_f[g] <= (RESULT == `CCS_ZERO_BYTE);
            end
            `CCS_SRC_BITTEST, `CCS_SRC_ROTATE: begin
              carry_f[g] <= CARRY_IN;
            end
            default: begin
              carry_f[g] <= CARRY_IN;
            end
          endcase
        end
      end
    end
  endgenerate
  // Pair shown one cycle after it or the context changes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CARRY <= `CCS_FLAG_RESET;
      ZERO <= `CCS_FLAG_RESET;
    end else begin
      CARRY <= carry_f[ctx];
      ZERO <= zero_f[ctx];
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CONTEXT <= CCS_CTX_NMI;
    end else begin
      CONTEXT <= ctx;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      STACK_LEVEL <= '0;
    end else begin
      STACK_LEVEL <= stk_level;
    end
  end
endmodule
`default_nettype wire

// *** hw/ccs_defines.svh ***
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
`define CCS_ADDR_PTR1 8'h80
`define CCS_ADDR_PTR2 8'h81
`define CCS_ADDR_SD1 8'h82
`define CCS_ADDR_SD2 8'h83
`define CCS_ADDR_WORK 8'hFF
`define CCS_PC_W 12
`define CCS_DEPTH 6
`define CCS_LVL_W 3
`define CCS_NMI_VECTOR 12'hFFC
`define CCS_RESET_VECTOR 12'hFFE
`define CCS_PC_ONE 12'h001
`define CCS_REG_RESET 8'h00
`define CCS_FLAG_RESET 1'b0
`define CCS_ZERO_BYTE 8'h00
`define CCS_N_CTX 3
`define CCS_SRC_ARITH 2'h0
`define CCS_SRC_LOGIC 2'h1
`define CCS_SRC_BITTEST 2'h2
`define CCS_SRC_ROTATE 2'h3
`endif

// *** hw/ccs_pkg.sv ***
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_CTX_NORMAL = 2'b00,
    CCS_CTX_IRQ = 2'b01,
    CCS_CTX_NMI = 2'b10
  } ccs_ctx_e;
  typedef enum logic [2:0] {
    CCS_PC_HOLD = 3'b000,
    CCS_PC_INC = 3'b001,
    CCS_PC_JUMP = 3'b010,
    CCS_PC_CALL = 3'b011,
    CCS_PC_BRANCH = 3'b100,
    CCS_PC_INTR = 3'b101,
    CCS_PC_RET = 3'b110,
    CCS_PC_INTERRUPT_EXIT_INSTR = 3'b111
  } ccs_pcop_e;
endpackage

// *** hw/ccs_return_stack.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defines.svh"
module ccs_return_stack
  import ccs_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic push, // Push a return address
  input wire logic pop, // Pop top level
  input wire logic [`CCS_PC_W-1:0] push_data, // Address to push
  output logic [`CCS_PC_W-1:0] top, // First level
  output logic empty, // No level holds data
  output logic [`CCS_LVL_W-1:0] level // Levels in use
);
  logic [`CCS_PC_W-1:0] lvl [`CCS_DEPTH];
  assign top = lvl[0];
  assign empty = (level == '0);
  genvar g;
  generate
    for (g = 0; g < `CCS_DEPTH; g++) begin : g_lvl
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl[g] <= '0;
        end else if (push) begin
          if (g == 0) begin
            lvl[g] <= push_data;
          end else begin
            lvl[g] <= lvl[g-1];
          end
        end else if (pop && !empty) begin
          if (g == `CCS_DEPTH-1) begin
            lvl[g] <= lvl[g];
          end else begin
            lvl[g] <= lvl[g+1];
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
    end else if (push) begin
      if (level != `CCS_LVL_W'(`CCS_DEPTH)) begin
        level <= level + `CCS_LVL_W'(1);
      end
    end else if (pop && !empty) begin
      level <= level - `CCS_LVL_W'(1);
    end
  end
endmodule
`default_nettype wire

// *** verification/ccs_core_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module ccs_core_asserts
  import ccs_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RSTN, // Reset
  input wire logic [2:0] PC_OP, // Op
  input wire logic [11:0] PC_TARGET, // Target
  input wire logic [7:0] BRANCH_OFFSET, // Offset
  input wire logic ENTER_NMI, // Entry
  input wire logic [7:0] DATA_ADDR, // Address
  input wire logic DATA_WE, // Write
  input wire logic [7:0] DATA_WDATA, // Data
  input wire logic [11:0] PROGRAM_COUNTER, // Counter
  input wire logic DATA_HIT, // Hit
  input wire logic [7:0] PTR1, // Pointer
  input wire logic [1:0] CONTEXT, // Context
  input wire logic [2:0] STACK_LEVEL // Levels
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  pc_step_a: assert property (
    PC_OP == 3'h1 |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 12'h001) else $error("step");
  pc_jump_a: assert property (
    PC_OP == 3'h2 |=> PROGRAM_COUNTER == $past(PC_TARGET)) else $error("jump");
  pc_branch_a: assert property (
    PC_OP == 3'h4 |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER +
    {{4{BRANCH_OFFSET[7]}}, BRANCH_OFFSET})) else $error("branch");
  stack_push_a: assert property (
    (PC_OP == 3'h3) ##1 (PC_OP == 3'h0) |=>
    (STACK_LEVEL == ($past(STACK_LEVEL) == 3'h6 ? 3'h6 : $past(STACK_LEVEL) + 3'h1)))
    else $error("push");
  empty_ret_a: assert property (
    (PC_OP != 3'h3 && PC_OP != 3'h5) ##1 (PC_OP == 3'h6 && STACK_LEVEL == 3'h0) |=>
    (PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 12'h001) ##1 (STACK_LEVEL == 3'h0))
    else $error("ret");
  map_hit_a: assert property (
    1'b1 |=> DATA_HIT == $past(DATA_ADDR inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hFF}))
    else $error("hit");
  ptr_write_a: assert property (
    DATA_WE && DATA_ADDR == 8'h80 |=> PTR1 == $past(DATA_WDATA)) else $error("ptr");
  nmi_entry_a: assert property (
    PC_OP == 3'h5 && ENTER_NMI |=> ##1 CONTEXT == 2'h2) else $error("nmi");
  reset_ctx_a: assert property (
    $rose(RSTN) |-> CONTEXT == 2'h2) else $error("reset");
endmodule
bind ccs_core ccs_core_asserts chk (
  .CLK(CLK),
  .RSTN(RSTN),
  .PC_OP(PC_OP),
  .PC_TARGET(PC_TARGET),
  .BRANCH_OFFSET(BRANCH_OFFSET),
  .ENTER_NMI(ENTER_NMI),
  .DATA_ADDR(DATA_ADDR),
  .DATA_WE(DATA_WE),
  .DATA_WDATA(DATA_WDATA),
  .PROGRAM_COUNTER(PROGRAM_COUNTER),
  .DATA_HIT(DATA_HIT),
  .PTR1(PTR1),
  .CONTEXT(CONTEXT),
  .STACK_LEVEL(STACK_LEVEL)
);
`default_nettype wire

// *** verification/ccs_save_ram.sv ***
`timescale 1ns/1ns
`default_nettype none
module ccs_save_ram (
  input wire logic clk, // Core clock
  input wire logic we, // Write strobe
  input wire logic [7:0] addr, // Data address
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata // Read data
);
  logic [7:0] mem [0:127];
  always_ff @(posedge clk) begin
    if (we && !addr[7]) begin
      mem[addr[6:0]] <= wdata;
    end
  end
  assign rdata = mem[addr[6:0]];
endmodule
`default_nettype wire

// *** verification/ccs_core_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module ccs_core_test;
  logic CLK = '0, RSTN = '0, ENTER_IRQ = '0, ENTER_NMI = '0, DATA_WE = '0;
  logic WORK_WE = '0, FLAG_WE = '0, CARRY_IN = '0, DATA_HIT, CARRY, ZERO;
  logic [2:0] PC_OP = '0;
  logic [2:0] STACK_LEVEL;
  logic [1:0] FLAG_SRC = '0;
  logic [1:0] CONTEXT;
  logic [11:0] PC_TARGET = '0;
  logic [11:0] PROGRAM_COUNTER;
  logic [7:0] BRANCH_OFFSET = '0, DATA_ADDR = '0, DATA_WDATA = '0, WORK_WDATA = '0, RESULT = '0;
  logic [7:0] DATA_RDATA, WORK, PTR1, PTR2, ram_q;
  logic [7:0] adr [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84};
  int n_mismatch = 0, comparisons = 0, cyc = 0, i;
  ccs_core uut (
    .CLK(CLK),
    .RSTN(RSTN),
    .PC_OP(PC_OP),
    .PC_TARGET(PC_TARGET),
    .BRANCH_OFFSET(BRANCH_OFFSET),
    .ENTER_IRQ(ENTER_IRQ),
    .ENTER_NMI(ENTER_NMI),
    .DATA_ADDR(DATA_ADDR),
    .DATA_WE(DATA_WE),
    .DATA_WDATA(DATA_WDATA),
    .WORK_WE(WORK_WE),
    .WORK_WDATA(WORK_WDATA),
    .FLAG_WE(FLAG_WE),
    .FLAG_SRC(FLAG_SRC),
    .RESULT(RESULT),
    .CARRY_IN(CARRY_IN),
    .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .DATA_RDATA(DATA_RDATA),
    .DATA_HIT(DATA_HIT),
    .WORK(WORK),
    .PTR1(PTR1),
    .PTR2(PTR2),
    .CARRY(CARRY),
    .ZERO(ZERO),
    .CONTEXT(CONTEXT),
    .STACK_LEVEL(STACK_LEVEL)
  );
  ccs_save_ram ram (.clk(CLK), .we(DATA_WE), .addr(DATA_ADDR), .wdata(DATA_WDATA), .rdata(ram_q));
  always #25 CLK = ~CLK;
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A quiet cycle follows each request so delayed outputs have landed
  task automatic op(input logic [2:0] code, input logic [11:0] tgt);
    @(negedge CLK);
    PC_OP = code;
    PC_TARGET = tgt;
    @(negedge CLK);
    PC_OP = 3'h0;
    @(negedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    DATA_ADDR = a;
    DATA_WDATA = d;
    DATA_WE = 1'h1;
    @(negedge CLK);
    DATA_WE = 1'h0;
    @(negedge CLK);
  endtask
  task automatic flg(input logic [1:0] src, input logic c, input logic [7:0] r);
    @(negedge CLK);
    {FLAG_WE, FLAG_SRC, CARRY_IN, RESULT} = {1'h1, src, c, r};
    @(negedge CLK);
    FLAG_WE = 1'h0;
    @(negedge CLK);
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(negedge CLK);
    RSTN = 1'h1;
    chk(PROGRAM_COUNTER, 12'hFFE);
    chk(CONTEXT, 2'h2);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      wr(adr[i], 8'h11 * 8'(i + 1));
      chk(DATA_RDATA, i < 5 ? 8'h11 * 8'(i + 1) : 8'h00);
      chk(DATA_HIT, i < 5);
    end
    chk(PTR1, 8'h11);
    chk(PTR2, 8'h22);
    chk(WORK, 8'h55);
    $display("register test done");
    op(3'h2, 12'h100);
    chk(PROGRAM_COUNTER, 12'h100);
    op(3'h1, 12'h000);
    chk(PROGRAM_COUNTER, 12'h101);
    BRANCH_OFFSET = 8'hFE;
    op(3'h4, 12'h000);
    chk(PROGRAM_COUNTER, 12'h0FF);
    $display("counter test done");
    for (i = 1; i < 8; i++) begin
      op(3'h3, 12'h200 + 12'(i));
    end
    chk(STACK_LEVEL, 3'h6);
    for (i = 6; i > 0; i--) begin
      op(3'h6, 12'h000);
      chk(PROGRAM_COUNTER, 12'h200 + 12'(i));
    end
    op(3'h6, 12'h000);
    chk(PROGRAM_COUNTER, 12'h202);
    chk(STACK_LEVEL, 3'h0);
    $display("stack test done");
    wr(8'h10, WORK);
    WORK_WDATA = 8'h00;
    WORK_WE = 1'h1;
    @(negedge CLK);
    chk(WORK, 8'h00);
    WORK_WDATA = ram_q;
    @(negedge CLK);
    WORK_WE = 1'h0;
    chk(WORK, 8'h55);
    flg(2'h0, 1'h1, 8'h00);
    chk({CARRY, ZERO}, 2'h3);
    op(3'h7, 12'h000);
    chk(CONTEXT, 2'h0);
    chk({CARRY, ZERO}, 2'h0);
    flg(2'h1, 1'h1, 8'h03);
    ENTER_IRQ = 1'h1;
    op(3'h5, 12'hFF0);
    chk(CONTEXT, 2'h1);
    chk({CARRY, ZERO}, 2'h0);
    flg(2'h0, 1'h0, 8'h00);
    flg(2'h2, 1'h1, 8'h05);
    chk({CARRY, ZERO}, 2'h3);
    ENTER_NMI = 1'h1;
    op(3'h5, 12'hFFC);
    chk({CONTEXT, CARRY, ZERO}, 4'hB);
    op(3'h3, 12'h300);
    op(3'h6, 12'h000);
    chk(PROGRAM_COUNTER, 12'hFFC);
    op(3'h7, 12'h000);
    chk({CONTEXT, CARRY, ZERO}, 4'h7);
    op(3'h7, 12'h000);
    chk({CONTEXT, CARRY, ZERO}, 4'h2);
    flg(2'h3, 1'h0, 8'h00);
    chk({CARRY, ZERO}, 2'h0);
    $display("flag test done");
    wrap_up();
  end
endmodule
`default_nettype wire
